// >>> rtl/rts_pkg.sv
// constants and types for the reset timeout sequencer
package rts_pkg;
    // ------------------------------------------------------------
    // timing
    // ------------------------------------------------------------
    localparam int unsigned SYS_CLK_HZ         = 50_000_000;
    localparam int unsigned POWER_UP_DELAY_MS  = 72;
    localparam int unsigned CRYSTAL_START_CNT  = 1024;
    localparam int unsigned PIN_FILTER_NS      = 200;
    localparam int unsigned PIN_FILTER_CYC     = (PIN_FILTER_NS * (SYS_CLK_HZ / 1_000_000)) / 1000;
    // ------------------------------------------------------------
    // register map
    // ------------------------------------------------------------
    localparam logic [11:0] ADDR_CAUSE   = 12'h000;
    localparam logic [11:0] ADDR_STATUS  = 12'h004;
    localparam logic [11:0] ADDR_CONFIG  = 12'h008;
    localparam logic [11:0] ADDR_CTRL    = 12'h00c;
    localparam int unsigned CAUSE_BROWNOUT_BIT = 0;
    localparam int unsigned CAUSE_POWERON_BIT  = 1;
    localparam logic [1:0]  CAUSE_RESET  = 2'h0;
    localparam logic [4:0]  CONFIG_RESET = 5'h00;
    localparam logic [15:0] PC_RESET_VEC = 16'h0000;
    localparam logic [15:0] PC_IRQ_VEC   = 16'h0004;
    // ------------------------------------------------------------
    // oscillator modes
    // ------------------------------------------------------------
    localparam logic [1:0]  OSC_LOW_POWER = 2'h0;
    localparam logic [1:0]  OSC_CRYSTAL   = 2'h1;
    localparam logic [1:0]  OSC_FAST      = 2'h2;
    localparam logic [1:0]  OSC_RC        = 2'h3;
    // ------------------------------------------------------------
    // reset kinds and states
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        KIND_POWER_ON  = 3'h0,
        KIND_PIN_RUN   = 3'h1,
        KIND_PIN_SLEEP = 3'h2,
        KIND_WDOG_RUN  = 3'h3,
        KIND_WDOG_WAKE = 3'h4,
        KIND_BROWNOUT  = 3'h5,
        KIND_IRQ_WAKE  = 3'h6,
        KIND_NONE      = 3'h7
    } rts_kind_t;

    typedef enum logic [4:0] {
        ST_RUN     = 5'b00001,
        ST_BROWN   = 5'b00010,
        ST_PWRUP   = 5'b00100,
        ST_XTAL    = 5'b01000,
        ST_PINHOLD = 5'b10000
    } rts_state_t;
endpackage : rts_pkg

// >>> rtl/rts_sequencer.sv
// reset timeout sequencer with apb status and control
//
// The placing of the registers and the APB register port were decided locally.
`timescale 1ns/1ps
module rts_sequencer #(
    parameter int unsigned RC_CLK_HZ     = 31_250,
    parameter int unsigned PWRUP_TICKS   = (rts_pkg::POWER_UP_DELAY_MS * RC_CLK_HZ) / 1000
) (
    input  wire logic        sys_clk,
    input  wire logic        resetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic             pready,
    output logic [31:0]      prdata,
    output logic             pslverr,
    input  wire logic        supply_rise,
    input  wire logic        brownout_low,
    input  wire logic        external_reset_pin,
    input  wire logic        watchdog_timeout,
    input  wire logic        irq_wake,
    input  wire logic        sleeping,
    input  wire logic        rc_tick,
    input  wire logic        osc_clk,
    output logic             core_reset,
    output logic             regs_reset,
    output logic             pc_load,
    output logic [15:0]      pc_value,
    output logic             external_reset_pin_oe,
    output logic             external_reset_pin_out
);
    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    typedef struct packed {
        logic [1:0]            rst_sync;
        logic [1:0]            pin_s;
        logic [1:0]            bo_s;
        logic [1:0]            por_s;
        logic [1:0]            wd_s;
        logic [1:0]            irq_s;
        logic [1:0]            slp_s;
        logic [1:0]            rc_s;
        logic [1:0]            osc_s;
        logic                  rc_d;
        logic                  osc_d;
        logic                  por_d;
        logic                  pin_f;
        logic [7:0]            pin_cnt;
        rts_pkg::rts_state_t   st;
        logic [31:0]           pw_cnt;
        logic [10:0]           xt_cnt;
        logic                  xt_need;
        logic [1:0]            cause;
        logic                  expired;
        logic                  pdown;
        logic [4:0]            cfg;
        rts_pkg::rts_kind_t    last_kind;
        logic                  core_rst;
        logic                  regs_rst;
        logic                  pc_ld;
        logic [15:0]           pc_val;
        logic                  pready;
        logic [31:0]           prdata;
        logic                  pslverr;
    } rts_regs_t;

    rts_regs_t s_r;
    rts_regs_t s_nxt;
    logic      rst_n_int;

    // ------------------------------------------------------------
    // reset synchroniser
    // ------------------------------------------------------------
    logic [1:0] rst_sync_r;
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            rst_sync_r <= 2'h0;
        end else begin
            rst_sync_r <= {rst_sync_r[0], 1'b1};
        end
    end
    assign rst_n_int = rst_sync_r[1];

    // ------------------------------------------------------------
    // helper signals
    // ------------------------------------------------------------
    // cfg: [0] delay_enable_n, [1] brownout_detect_enable, [3:2] osc mode, [4] irq wake vector enable (PC_IRQ_VEC, else 16'h0001)
    logic pin_low;
    logic bo_act;
    logic rc_edge;
    logic osc_edge;
    logic xtal_mode;
    logic por_ev;
    logic wd_ev;
    logic irq_ev;
    logic acc;
    logic [31:0] rdv;

    always_comb begin
        s_nxt = s_r;
        // ------------------------------------------------------------
        // input synchronisers and edges
        // ------------------------------------------------------------
        s_nxt.rst_sync = 2'h0;
        s_nxt.pin_s = {s_r.pin_s[0], external_reset_pin};
        s_nxt.bo_s  = {s_r.bo_s[0], brownout_low};
        s_nxt.por_s = {s_r.por_s[0], supply_rise};
        s_nxt.wd_s  = {s_r.wd_s[0], watchdog_timeout};
        s_nxt.irq_s = {s_r.irq_s[0], irq_wake};
        s_nxt.slp_s = {s_r.slp_s[0], sleeping};
        s_nxt.rc_s  = {s_r.rc_s[0], rc_tick};
        s_nxt.osc_s = {s_r.osc_s[0], osc_clk};
        s_nxt.rc_d  = s_r.rc_s[1];
        s_nxt.osc_d = s_r.osc_s[1];
        s_nxt.por_d = s_r.por_s[1];
        rc_edge   = s_r.rc_s[1] & ~s_r.rc_d;
        osc_edge  = s_r.osc_s[1] & ~s_r.osc_d;
        xtal_mode = (s_r.cfg[3:2] != rts_pkg::OSC_RC);
        // power-on acts once per rising event, not once per cycle held
        por_ev    = s_r.por_s[1] & ~s_r.por_d;
        wd_ev     = s_r.wd_s[1];
        irq_ev    = s_r.irq_s[1];
        bo_act    = s_r.cfg[1] & s_r.bo_s[1];

        // ------------------------------------------------------------
        // pin filter
        // ------------------------------------------------------------
        // pin filter: level must persist before it is accepted
        if (s_r.pin_s[1] == s_r.pin_f) begin
            s_nxt.pin_cnt = 8'h00;
        end else if (s_r.pin_cnt >= 8'(rts_pkg::PIN_FILTER_CYC)) begin
            s_nxt.pin_f   = s_r.pin_s[1];
            s_nxt.pin_cnt = 8'h00;
        end else begin
            s_nxt.pin_cnt = s_r.pin_cnt + 8'h01;
        end
        pin_low = ~s_r.pin_f;

        s_nxt.pc_ld    = 1'b0;
        s_nxt.regs_rst = 1'b0;

        // ------------------------------------------------------------
        // reset kinds
        // ------------------------------------------------------------
        // reset kinds, priority: power-on, brown-out, pin, watchdog, irq
        if (por_ev) begin
            s_nxt.st        = s_r.cfg[0] ? rts_pkg::ST_XTAL : rts_pkg::ST_PWRUP;
            s_nxt.pw_cnt    = 32'h0;
            s_nxt.xt_cnt    = 11'h0;
            s_nxt.xt_need   = 1'b1;
            s_nxt.cause[rts_pkg::CAUSE_POWERON_BIT] = 1'b0;
            s_nxt.expired   = 1'b1;
            s_nxt.pdown     = 1'b1;
            s_nxt.core_rst  = 1'b1;
            s_nxt.regs_rst  = 1'b1;
            s_nxt.last_kind = rts_pkg::KIND_POWER_ON;
        end else if (bo_act) begin
            s_nxt.st        = rts_pkg::ST_BROWN;
            s_nxt.pw_cnt    = 32'h0;
            s_nxt.xt_cnt    = 11'h0;
            s_nxt.xt_need   = 1'b1;
            s_nxt.cause[rts_pkg::CAUSE_BROWNOUT_BIT] = 1'b0;
            s_nxt.expired   = 1'b1;
            s_nxt.pdown     = 1'b1;
            s_nxt.core_rst  = 1'b1;
            // one register reset pulse per dip, not one per cycle low
            s_nxt.regs_rst  = (s_r.st != rts_pkg::ST_BROWN);
            s_nxt.last_kind = rts_pkg::KIND_BROWNOUT;
        end else if (pin_low && s_r.st == rts_pkg::ST_RUN) begin
            s_nxt.st       = rts_pkg::ST_PINHOLD;
            s_nxt.core_rst = 1'b1;
            s_nxt.regs_rst = 1'b1;
            if (s_r.slp_s[1]) begin
                s_nxt.expired   = 1'b1;
                s_nxt.pdown     = 1'b0;
                s_nxt.last_kind = rts_pkg::KIND_PIN_SLEEP;
            end else begin
                s_nxt.last_kind = rts_pkg::KIND_PIN_RUN;
            end
        end else if (wd_ev && s_r.st == rts_pkg::ST_RUN) begin
            if (s_r.slp_s[1]) begin
                s_nxt.expired   = 1'b0;
                s_nxt.pdown     = 1'b0;
                s_nxt.last_kind = rts_pkg::KIND_WDOG_WAKE;
                s_nxt.core_rst  = 1'b1;
                s_nxt.xt_need   = xtal_mode;
                s_nxt.xt_cnt    = 11'h0;
                s_nxt.st        = rts_pkg::ST_XTAL;
            end else begin
                s_nxt.expired   = 1'b0;
                s_nxt.pdown     = 1'b1;
                s_nxt.last_kind = rts_pkg::KIND_WDOG_RUN;
                s_nxt.core_rst  = 1'b1;
                s_nxt.regs_rst  = 1'b1;
                s_nxt.xt_need   = 1'b0;
                s_nxt.st        = rts_pkg::ST_XTAL;
            end
        end else if (irq_ev && s_r.slp_s[1] && s_r.st == rts_pkg::ST_RUN) begin
            s_nxt.expired   = 1'b1;
            s_nxt.pdown     = 1'b0;
            s_nxt.last_kind = rts_pkg::KIND_IRQ_WAKE;
            s_nxt.core_rst  = 1'b1;
            s_nxt.xt_need   = xtal_mode;
            s_nxt.xt_cnt    = 11'h0;
            s_nxt.st        = rts_pkg::ST_XTAL;
        end else begin
            // ------------------------------------------------------------
            // start-up sequence
            // ------------------------------------------------------------
            case (s_r.st)
                rts_pkg::ST_RUN: begin
                    s_nxt.core_rst = 1'b0;
                end
                rts_pkg::ST_BROWN: begin
                    s_nxt.st = rts_pkg::ST_PWRUP;
                end
                rts_pkg::ST_PWRUP: begin
                    if (s_r.pw_cnt >= PWRUP_TICKS) begin
                        s_nxt.st = rts_pkg::ST_XTAL;
                    end else if (rc_edge) begin
                        s_nxt.pw_cnt = s_r.pw_cnt + 32'h1;
                    end
                end
                rts_pkg::ST_XTAL: begin
                    if (!(s_r.xt_need && xtal_mode) ||
                        s_r.xt_cnt >= 11'(rts_pkg::CRYSTAL_START_CNT)) begin
                        s_nxt.st = rts_pkg::ST_PINHOLD;
                    end else if (osc_edge) begin
                        s_nxt.xt_cnt = s_r.xt_cnt + 11'h001;
                    end
                end
                rts_pkg::ST_PINHOLD: begin
                    if (!pin_low) begin
                        s_nxt.st       = rts_pkg::ST_RUN;
                        s_nxt.core_rst = 1'b0;
                        s_nxt.pc_ld    = 1'b1;
                        if (s_r.last_kind == rts_pkg::KIND_WDOG_WAKE ||
                            s_r.last_kind == rts_pkg::KIND_IRQ_WAKE) begin
                            s_nxt.pc_val = (s_r.last_kind == rts_pkg::KIND_IRQ_WAKE && s_r.cfg[4])
                                ? rts_pkg::PC_IRQ_VEC : 16'h0001;
                        end else begin
                            s_nxt.pc_val = rts_pkg::PC_RESET_VEC;
                        end
                    end
                end
                default: begin
                    s_nxt.st = rts_pkg::ST_RUN;
                end
            endcase
        end

        // ------------------------------------------------------------
        // apb slave
        // ------------------------------------------------------------
        // apb slave, one wait state
        acc = psel & penable & ~s_r.pready;
        s_nxt.pready  = acc;
        s_nxt.pslverr = 1'b0;
        rdv = 32'h0000_0000;
        case (paddr)
            rts_pkg::ADDR_CAUSE:  rdv = {30'h0, s_r.cause};
            rts_pkg::ADDR_STATUS: rdv = {24'h0, 5'(s_r.st), s_r.expired, s_r.pdown, 1'b0};
            rts_pkg::ADDR_CONFIG: rdv = {27'h0, s_r.cfg};
            rts_pkg::ADDR_CTRL:   rdv = {29'h0, s_r.last_kind};
            default: begin
                rdv = 32'h0000_0000;
                if (acc) begin
                    s_nxt.pslverr = 1'b1;
                end
            end
        endcase
        s_nxt.prdata = (acc && !pwrite) ? rdv : 32'h0000_0000;
        // ------------------------------------------------------------
        // register writes
        // ------------------------------------------------------------
        if (acc && pwrite) begin
            if (paddr == rts_pkg::ADDR_CAUSE) begin
                s_nxt.cause = pwdata[1:0];
                if (por_ev) begin
                    s_nxt.cause[rts_pkg::CAUSE_POWERON_BIT] = 1'b0;
                end
                if (bo_act) begin
                    s_nxt.cause[rts_pkg::CAUSE_BROWNOUT_BIT] = 1'b0;
                end
            end else if (paddr == rts_pkg::ADDR_CONFIG) begin
                s_nxt.cfg = pwdata[4:0];
            end
        end
    end

    // ------------------------------------------------------------
    // state register
    // ------------------------------------------------------------
    always_ff @(posedge sys_clk or negedge rst_n_int) begin
        if (!rst_n_int) begin
            s_r          <= '0;
            s_r.st       <= rts_pkg::ST_RUN;
            s_r.cfg      <= rts_pkg::CONFIG_RESET;
            s_r.cause    <= rts_pkg::CAUSE_RESET;
            s_r.pin_f    <= 1'b1;
            s_r.pin_s    <= 2'h3;
            s_r.core_rst <= 1'b1;
            s_r.last_kind <= rts_pkg::KIND_NONE;
        end else begin
            s_r <= s_nxt;
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    assign core_reset             = s_r.core_rst;
    assign regs_reset             = s_r.regs_rst;
    assign pc_load                = s_r.pc_ld;
    assign pc_value               = s_r.pc_val;
    assign pready                 = s_r.pready;
    assign prdata                 = s_r.prdata;
    assign pslverr                = s_r.pslverr;
    assign external_reset_pin_oe  = s_r.rst_sync[0];
    assign external_reset_pin_out = s_r.rst_sync[1];
endmodule : rts_sequencer

// >>> tb/rts_sequencer_chk.sv
// concurrent checks on the reset timeout sequencer ports
`timescale 1ns/1ps
module rts_sequencer_chk #(
    parameter int unsigned RC_CLK_HZ   = 31_250,
    parameter int unsigned PWRUP_TICKS = 2250
) (
    input wire logic        sys_clk,
    input wire logic        resetn,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic        brownout_low,
    input wire logic        external_reset_pin,
    input wire logic        watchdog_timeout,
    input wire logic        irq_wake,
    input wire logic        sleeping,
    input wire logic        core_reset,
    input wire logic        regs_reset,
    input wire logic        pc_load,
    input wire logic [15:0] pc_value,
    input wire logic        external_reset_pin_oe
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!resetn);

    pin_not_driven_a: assert property (!external_reset_pin_oe)
        else $error("reset pin driven");
    apb_wait_a: assert property (psel && $rose(penable) |=> pready)
        else $error("apb answer late");
    ready_pulse_a: assert property (pready |=> !pready)
        else $error("pready longer than one cycle");
    slverr_ready_a: assert property (pslverr |-> pready)
        else $error("pslverr without pready");
    pc_vector_a: assert property (pc_load |-> (pc_value == rts_pkg::PC_RESET_VEC
        || pc_value == 16'h0001 || pc_value == rts_pkg::PC_IRQ_VEC))
        else $error("pc load value bad");
    short_pin_a: assert property (!core_reset && $rose(external_reset_pin)
        && $past(external_reset_pin, 6) |-> !core_reset [*8])
        else $error("short pin pulse caused reset");
    long_pin_a: assert property (!external_reset_pin [*8] ##1 !external_reset_pin [*8]
        |-> ##[0:6] core_reset)
        else $error("held pin gave no reset");
    brown_hold_a: assert property (core_reset && brownout_low |=> core_reset)
        else $error("released during brownout");
    brown_delay_a: assert property (core_reset && $fell(brownout_low) |-> core_reset [*4])
        else $error("no delay after brownout");
    wake_keep_a: assert property (sleeping && external_reset_pin
        && (irq_wake || watchdog_timeout) |-> !regs_reset [*8])
        else $error("wake reset registers");
    regs_pulse_a: assert property (regs_reset |=> !regs_reset)
        else $error("regs_reset not a pulse");
endmodule : rts_sequencer_chk

bind rts_sequencer rts_sequencer_chk #(.RC_CLK_HZ(RC_CLK_HZ), .PWRUP_TICKS(PWRUP_TICKS))
    rts_sequencer_chk_i (.sys_clk(sys_clk), .resetn(resetn), .psel(psel), .penable(penable),
    .pready(pready), .pslverr(pslverr), .brownout_low(brownout_low),
    .external_reset_pin(external_reset_pin), .watchdog_timeout(watchdog_timeout),
    .irq_wake(irq_wake), .sleeping(sleeping), .core_reset(core_reset),
    .regs_reset(regs_reset), .pc_load(pc_load), .pc_value(pc_value),
    .external_reset_pin_oe(external_reset_pin_oe));

// >>> tb/tb_rts_sequencer.sv
// self-checking bench for the reset timeout sequencer
`timescale 1ns/1ps
module tb_rts_sequencer;
    logic        sys_clk = 1'b0, resetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0000_0000, prdata;
    logic        pready, pslverr, core_reset, regs_reset, pc_load, pin_oe, pin_out;
    logic [15:0] pc_value;
    logic        supply_rise = 1'b0, brownout_low = 1'b0, external_reset_pin = 1'b1;
    logic        watchdog_timeout = 1'b0, irq_wake = 1'b0, sleeping = 1'b0;
    logic        rc_tick = 1'b0, osc_clk = 1'b0;
    logic [4:0]  div = 5'h00;
    int          miscompares = 0, n_tests = 0, n_rr = 0, n_pd = 0;

    rts_sequencer #(.PWRUP_TICKS(4)) rts_sequencer_i (
        .sys_clk(sys_clk), .resetn(resetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
        .supply_rise(supply_rise), .brownout_low(brownout_low),
        .external_reset_pin(external_reset_pin), .watchdog_timeout(watchdog_timeout),
        .irq_wake(irq_wake), .sleeping(sleeping), .rc_tick(rc_tick), .osc_clk(osc_clk),
        .core_reset(core_reset), .regs_reset(regs_reset), .pc_load(pc_load),
        .pc_value(pc_value), .external_reset_pin_oe(pin_oe), .external_reset_pin_out(pin_out));

    always #10 sys_clk = ~sys_clk;
    // oscillator period 8 cycles, rc tick period 32 cycles
    always @(posedge sys_clk) begin
        div <= div + 5'h01;
        osc_clk <= div[2];
        rc_tick <= div[4];
        if (regs_reset === 1'b1) n_rr <= n_rr + 1;
        if (resetn && (pin_oe !== 1'b0 || pin_out !== 1'b0)) n_pd <= n_pd + 1;
    end

    task end_of_test;
        $display("comparisons %0d miscompares %0d", n_tests, miscompares);
        if (miscompares == 0 && n_tests > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : end_of_test

    task chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        n_tests++;
        if (got !== exp) begin
            $display("wrong value %s expected %h seen %h", what, exp, got);
            miscompares++;
        end
    endtask : chk

    task apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
             output logic [31:0] q, output logic e);
        int n;
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge sys_clk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge sys_clk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge sys_clk);
        if (n >= 20) begin
            miscompares++;
            end_of_test;
        end
    endtask : apb

    task rd_chk(input string what, input logic [11:0] a, input logic [31:0] m,
                input logic [31:0] exp);
        logic [31:0] q;
        logic        e;
        apb(1'b0, a, 32'h0000_0000, q, e);
        chk(what, exp, q & m);
    endtask : rd_chk

    task kind_chk(input logic [2:0] k, input logic [1:0] tp, input logic [1:0] cm,
                  input logic [1:0] ce);
        rd_chk("kind", rts_pkg::ADDR_CTRL, 32'h0000_0007, {29'h0, k});
        rd_chk("status", rts_pkg::ADDR_STATUS, 32'h0000_0006, {29'h0, tp, 1'b0});
        rd_chk("cause", rts_pkg::ADDR_CAUSE, {30'h0, cm}, {30'h0, ce});
    endtask : kind_chk

    task wait_load(input int lim, output int cyc, output logic [15:0] pc);
        cyc = 0;
        while (pc_load !== 1'b1 && cyc < lim) begin
            @(posedge sys_clk);
            cyc++;
        end
        pc = pc_value;
        if (cyc >= lim) begin
            miscompares++;
            end_of_test;
        end
    endtask : wait_load

    task t_regs;
        logic [31:0] q;
        logic        e;
        rd_chk("cause rst", rts_pkg::ADDR_CAUSE, 32'h3, {30'h0, rts_pkg::CAUSE_RESET});
        rd_chk("config rst", rts_pkg::ADDR_CONFIG, 32'h1f, {27'h0, rts_pkg::CONFIG_RESET});
        apb(1'b1, rts_pkg::ADDR_CAUSE, 32'h0000_0003, q, e);
        rd_chk("cause rw", rts_pkg::ADDR_CAUSE, 32'h3, 32'h3);
        apb(1'b1, 12'h010, 32'hffff_ffff, q, e);
        chk("unmapped wr err", 32'h1, {31'h0, e});
        apb(1'b0, 12'h010, 32'h0000_0000, q, e);
        chk("unmapped rd err", 32'h1, {31'h0, e});
        chk("unmapped rd data", 32'h0, q);
    endtask : t_regs

    task t_por;
        int          cyc;
        logic [15:0] pc;
        supply_rise <= 1'b1;
        repeat (3) @(posedge sys_clk);
        supply_rise <= 1'b0;
        wait_load(20000, cyc, pc);
        chk("por length", 32'h1, {31'h0, cyc >= 8270 && cyc <= 8600});
        chk("por pc", 32'h0, {16'h0, pc});
        kind_chk(rts_pkg::KIND_POWER_ON, 2'b11, 2'b10, 2'b00);
    endtask : t_por

    task t_brown;
        logic [31:0] q;
        logic        e;
        int          cyc;
        logic [15:0] pc;
        apb(1'b1, rts_pkg::ADDR_CONFIG, 32'h0000_001f, q, e);
        apb(1'b1, rts_pkg::ADDR_CAUSE, 32'h0000_0003, q, e);
        brownout_low <= 1'b1;
        repeat (60) @(posedge sys_clk);
        brownout_low <= 1'b0;
        repeat (40) @(posedge sys_clk);
        // second dip while the delay runs
        brownout_low <= 1'b1;
        repeat (60) @(posedge sys_clk);
        brownout_low <= 1'b0;
        wait_load(2000, cyc, pc);
        chk("brown delay", 32'h1, {31'h0, cyc >= 96 && cyc < 400});
        chk("brown pc", 32'h0, {16'h0, pc});
        kind_chk(rts_pkg::KIND_BROWNOUT, 2'b11, 2'b11, 2'b10);
    endtask : t_brown

    task t_short;
        logic seen;
        seen = 1'b0;
        external_reset_pin <= 1'b0;
        repeat (5) @(posedge sys_clk);
        external_reset_pin <= 1'b1;
        repeat (30) begin
            @(posedge sys_clk);
            seen = seen | core_reset;
        end
        chk("short pulse", 32'h0, {31'h0, seen});
    endtask : t_short

    task ev(input logic slp, input logic wd, input logic irq, input logic low,
            input logic [2:0] k, input logic [1:0] tp, input logic [15:0] pcx, input logic rr);
        int          cyc, r0;
        logic [15:0] pc;
        r0 = n_rr;
        sleeping <= slp;
        watchdog_timeout <= wd;
        irq_wake <= irq;
        external_reset_pin <= !low;
        repeat (low ? 40 : 2) @(posedge sys_clk);
        watchdog_timeout <= 1'b0;
        irq_wake <= 1'b0;
        external_reset_pin <= 1'b1;
        wait_load(300, cyc, pc);
        chk("release time", 32'h1, {31'h0, cyc < 40});
        chk("pc", {16'h0, pcx}, {16'h0, pc});
        sleeping <= 1'b0;
        repeat (4) @(posedge sys_clk);
        chk("regs reset", {31'h0, rr}, {31'h0, n_rr != r0});
        kind_chk(k, tp, 2'b11, 2'b10);
    endtask : ev

    task t_resets;
        ev(1'b0, 1'b0, 1'b0, 1'b1, rts_pkg::KIND_PIN_RUN, 2'b11, 16'h0000, 1'b1);
        ev(1'b0, 1'b1, 1'b0, 1'b0, rts_pkg::KIND_WDOG_RUN, 2'b01, 16'h0000, 1'b1);
        ev(1'b1, 1'b0, 1'b0, 1'b1, rts_pkg::KIND_PIN_SLEEP, 2'b10, 16'h0000, 1'b1);
        ev(1'b1, 1'b1, 1'b0, 1'b0, rts_pkg::KIND_WDOG_WAKE, 2'b00, 16'h0001, 1'b0);
        ev(1'b1, 1'b0, 1'b1, 1'b0, rts_pkg::KIND_IRQ_WAKE, 2'b10, 16'h0004, 1'b0);
        chk("pin drive count", 32'h0000_0000, n_pd);
    endtask : t_resets

    task t_por_fast;
        int          cyc;
        logic [15:0] pc;
        supply_rise <= 1'b1;
        repeat (3) @(posedge sys_clk);
        supply_rise <= 1'b0;
        wait_load(300, cyc, pc);
        chk("por no delay", 32'h0000_0001, {31'h0, cyc < 40});
        chk("por fast pc", 32'h0000_0000, {16'h0, pc});
        kind_chk(rts_pkg::KIND_POWER_ON, 2'b11, 2'b10, 2'b00);
    endtask : t_por_fast

    initial begin
        repeat (6) @(posedge sys_clk);
        resetn <= 1'b1;
        repeat (4) @(posedge sys_clk);
        t_regs;
        t_por;
        t_brown;
        t_short;
        t_resets;
        t_por_fast;
        end_of_test;
    end
endmodule : tb_rts_sequencer
